// file: hdl/ckr_top.sv
// clock output routing and configuration registers
`include "ckr_consts.svh"
`default_nettype none
module ckr_top
  import ckr_pkg::*;
(
  input wire logic i_clk, // 40 MHz system clock
  input wire logic i_rst, // async reset, active high
  input wire ckr_req_t i_req, // decoded register access
  output var logic [15:0] o_rdata, // read data, one cycle after rd
  input wire logic i_fuse_load, // pulse: copy fuse image to registers
  input wire logic [15:0] i_fuse_div1_ab, // fuse image, first register
  input wire logic [15:0] i_fuse_oe_aux, // fuse image, second register
  input wire logic i_fd0_clk, // fractional divider 0 output
  input wire logic i_fd1_clk, // fractional divider 1 output
  input wire logic i_ch0_clk, // channel divider 0 output
  input wire logic i_ch1_src, // channel divider 1 source select
  input wire logic i_pair_ab_off_state, // 1: float a/b when off
  input wire logic i_pair_cd_off_state, // 1: float c/d when off
  input wire logic i_oe_pin, // output enable pin
  input wire logic i_clk_ready, // clock ready status
  output var ckr_pins_t o_pin_level, // pin output values
  output var ckr_pins_t o_pin_drive, // pin output enables
  output var logic [7:0] o_frac_div1_numerator // numerator high byte
);

  // decoded format of a pair
  function automatic ckr_fmt_t fmt_decode(input logic [2:0] code);
    ckr_fmt_t f;
    f = '0;
    case (code)
      3'h4: f.first_on = 1'b1;
      3'h5: f.second_on = 1'b1;
      3'h6: f = '{first_on: 1'b1, second_on: 1'b1, invert: 1'b1};
      3'h7: f = '{first_on: 1'b1, second_on: 1'b1, invert: 1'b0};
      default: f = '0; // reserved codes keep the pair quiet
    endcase
    return f;
  endfunction : fmt_decode

  // half period in source rising edges for the channel 1 divider
  function automatic logic [4:0] half_ch1(input logic [2:0] code);
    case (code)
      3'h1: return `CKR_HALF_CH1_1;
      3'h2: return `CKR_HALF_CH1_2;
      3'h3: return `CKR_HALF_CH1_3;
      3'h4: return `CKR_HALF_CH1_4;
      3'h5: return `CKR_HALF_CH1_5;
      3'h6: return `CKR_HALF_CH1_6;
      3'h7: return `CKR_HALF_CH1_7;
      default: return 5'h00;
    endcase
  endfunction : half_ch1

  // half period in source rising edges for the aux divider
  function automatic logic [4:0] half_aux(input logic [1:0] code);
    case (code)
      2'h1: return `CKR_HALF_AUX_1;
      2'h2: return `CKR_HALF_AUX_2;
      2'h3: return `CKR_HALF_AUX_3;
      default: return 5'h00;
    endcase
  endfunction : half_aux

  // configuration registers
  logic [15:0] div1_and_pair_ab_format;
  logic [15:0] output_enable_and_aux_pin_config;
  logic [15:0] next_div1_ab;
  logic [15:0] next_oe_aux;
  logic [15:0] next_rdata;

  // writes keep reserved bits at fixed values; a fuse load wins over a write
  always_comb begin
    next_div1_ab = div1_and_pair_ab_format;
    next_oe_aux = output_enable_and_aux_pin_config;
    next_rdata = o_rdata;
    if (i_fuse_load) begin
      next_div1_ab = i_fuse_div1_ab & `CKR_WMASK_DIV1_AB;
      next_oe_aux = (i_fuse_oe_aux & `CKR_WMASK_OE_AUX)
          | `CKR_FIXED_OE_AUX;
    end else if (i_req.wr) begin
      if (i_req.addr == `CKR_ADDR_DIV1_AB) begin
        next_div1_ab = i_req.wdata & `CKR_WMASK_DIV1_AB;
      end else if (i_req.addr == `CKR_ADDR_OE_AUX) begin
        next_oe_aux = (i_req.wdata & `CKR_WMASK_OE_AUX)
            | `CKR_FIXED_OE_AUX;
      end
    end
    if (i_req.rd) begin
      if (i_req.addr == `CKR_ADDR_DIV1_AB) begin
        next_rdata = div1_and_pair_ab_format;
      end else if (i_req.addr == `CKR_ADDR_OE_AUX) begin
        next_rdata = output_enable_and_aux_pin_config;
      end else begin
        next_rdata = 16'h0000; // other offsets are not held here
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div1_and_pair_ab_format <= `CKR_RST_DIV1_AB;
      output_enable_and_aux_pin_config <= `CKR_RST_OE_AUX;
      o_rdata <= 16'h0000;
    end else begin
      div1_and_pair_ab_format <= next_div1_ab;
      output_enable_and_aux_pin_config <= next_oe_aux;
      o_rdata <= next_rdata;
    end
  end

  // field views
  logic [2:0] chan1_divide_ratio;
  logic [2:0] pair_ab_format;
  logic [2:0] pair_cd_format;
  logic [1:0] aux_divide;
  logic aux_clock_source_select;
  logic pair_cd_enable;
  logic pair_cd_source_select;
  logic pair_ab_enable;
  logic oe_polarity;
  ckr_aux_func_t aux_pin_function;
  assign chan1_divide_ratio =
      div1_and_pair_ab_format[`CKR_CHAN1_DIVIDE_RATIO_MSB:`CKR_CHAN1_DIVIDE_RATIO_LSB];
  assign o_frac_div1_numerator =
      div1_and_pair_ab_format[`CKR_FD1_NUM_MSB:`CKR_FD1_NUM_LSB];
  assign pair_ab_format =
      div1_and_pair_ab_format[`CKR_AB_FMT_MSB:`CKR_AB_FMT_LSB];
  assign pair_cd_format =
      output_enable_and_aux_pin_config[`CKR_CD_FMT_MSB:`CKR_CD_FMT_LSB];
  assign aux_divide =
      output_enable_and_aux_pin_config[`CKR_AUX_DIV_MSB:`CKR_AUX_DIV_LSB];
  assign aux_pin_function = ckr_aux_func_t'(
      output_enable_and_aux_pin_config[`CKR_AUX_FUNC_MSB:`CKR_AUX_FUNC_LSB]);
  assign aux_clock_source_select =
      output_enable_and_aux_pin_config[`CKR_AUX_SRC_BIT];
  assign pair_cd_enable = output_enable_and_aux_pin_config[`CKR_CD_EN_BIT];
  assign pair_cd_source_select =
      output_enable_and_aux_pin_config[`CKR_CD_SRC_BIT];
  assign pair_ab_enable = output_enable_and_aux_pin_config[`CKR_AB_EN_BIT];
  assign oe_polarity = output_enable_and_aux_pin_config[`CKR_OE_POL_BIT];

  // two-flop synchronisers; a third stage gives the previous sampled level
  // so edge detection never looks at the first stage
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [1:0] prev;
  logic fd0_rise, fd1_rise, ch0_level, oe_level, ready_level;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      prev <= 2'h0;
    end else begin
      sync1 <= {i_fd0_clk, i_fd1_clk, i_ch0_clk, i_oe_pin, i_clk_ready,
          i_ch1_src};
      sync2 <= sync1;
      prev <= sync2[5:4];
    end
  end
  assign fd0_rise = sync2[5] & ~prev[1];
  assign fd1_rise = sync2[4] & ~prev[0];
  assign ch0_level = sync2[3];
  assign oe_level = sync2[2] ^ oe_polarity;
  assign ready_level = sync2[1];

  // channel 1 and aux dividers count rising edges of their source; the
  // source must run well below half of i_clk to be seen at all
  logic [4:0] ch1_cnt;
  logic [4:0] aux_cnt;
  logic ch1_out;
  logic aux_out;
  logic [4:0] next_ch1_cnt;
  logic [4:0] next_aux_cnt;
  logic next_ch1_out;
  logic next_aux_out;
  logic ch1_tick, aux_tick;
  always_comb begin
    ch1_tick = sync2[0] ? fd1_rise : fd0_rise;
    aux_tick = aux_clock_source_select ? fd1_rise : fd0_rise;
    next_ch1_cnt = ch1_cnt;
    next_ch1_out = ch1_out;
    next_aux_cnt = aux_cnt;
    next_aux_out = aux_out;
    if (half_ch1(chan1_divide_ratio) == 5'h00) begin
      next_ch1_cnt = 5'h00;
      next_ch1_out = 1'b0;
    end else if (ch1_tick) begin
      if (ch1_cnt + 5'h01 >= half_ch1(chan1_divide_ratio)) begin
        next_ch1_cnt = 5'h00;
        next_ch1_out = ~ch1_out;
      end else begin
        next_ch1_cnt = ch1_cnt + 5'h01;
      end
    end
    if (half_aux(aux_divide) == 5'h00) begin
      next_aux_cnt = 5'h00;
      next_aux_out = 1'b0;
    end else if (aux_tick) begin
      if (aux_cnt + 5'h01 >= half_aux(aux_divide)) begin
        next_aux_cnt = 5'h00;
        next_aux_out = ~aux_out;
      end else begin
        next_aux_cnt = aux_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ch1_cnt <= 5'h00;
      aux_cnt <= 5'h00;
      ch1_out <= 1'b0;
      aux_out <= 1'b0;
    end else begin
      ch1_cnt <= next_ch1_cnt;
      aux_cnt <= next_aux_cnt;
      ch1_out <= next_ch1_out;
      aux_out <= next_aux_out;
    end
  end

  // pin routing; disabled pins ground or float per the pair's off state
  ckr_fmt_t ab_fmt;
  ckr_fmt_t cd_fmt;
  ckr_pins_t next_level;
  ckr_pins_t next_drive;
  logic ab_on;
  logic cd_on;
  logic cd_src;
  always_comb begin
    ab_fmt = fmt_decode(pair_ab_format);
    cd_fmt = fmt_decode(pair_cd_format);
    ab_on = pair_ab_enable & oe_level;
    cd_on = pair_cd_enable & oe_level;
    cd_src = pair_cd_source_select ? ch1_out : ch0_level;
    next_level = '0;
    next_drive.a = ~i_pair_ab_off_state;
    next_drive.b = ~i_pair_ab_off_state;
    next_drive.c = ~i_pair_cd_off_state;
    next_drive.d = ~i_pair_cd_off_state;
    next_drive.aux = 1'b1;
    if (ab_on && ab_fmt.first_on) begin
      next_level.a = ch0_level;
      next_drive.a = 1'b1;
    end
    if (ab_on && ab_fmt.second_on) begin
      next_level.b = ch0_level ^ ab_fmt.invert;
      next_drive.b = 1'b1;
    end
    if (cd_on && cd_fmt.first_on) begin
      next_level.c = cd_src;
      next_drive.c = 1'b1;
    end
    if (cd_on && cd_fmt.second_on) begin
      next_level.d = cd_src ^ cd_fmt.invert;
      next_drive.d = 1'b1;
    end
    case (aux_pin_function)
      CKR_AUX_LOW: next_level.aux = 1'b0;
      CKR_AUX_HIZ: next_drive.aux = 1'b0;
      CKR_AUX_CLOCK: next_level.aux = aux_out;
      CKR_AUX_READY: next_level.aux = ready_level;
      default: next_level.aux = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_level <= '0;
      o_pin_drive <= '0;
    end else begin
      o_pin_level <= next_level;
      o_pin_drive <= next_drive;
    end
  end

endmodule : ckr_top
`default_nettype wire

// file: hdl/ckr_consts.svh
// register offsets, field positions, reset values and divider counts
`ifndef CKR_CONSTS_SVH
`define CKR_CONSTS_SVH
`define CKR_ADDR_DIV1_AB 8'h06
`define CKR_ADDR_OE_AUX 8'h07
`define CKR_RST_DIV1_AB 16'h0aa7
`define CKR_RST_OE_AUX 16'h5d1f
// divider1_and_pair_ab_format fields
`define CKR_CHAN1_DIVIDE_RATIO_MSB 15
`define CKR_CHAN1_DIVIDE_RATIO_LSB 13
`define CKR_FD1_NUM_MSB 12
`define CKR_FD1_NUM_LSB 5
`define CKR_AB_FMT_MSB 2
`define CKR_AB_FMT_LSB 0
// output_enable_and_aux_pin_config fields
`define CKR_AUX_FUNC_MSB 14
`define CKR_AUX_FUNC_LSB 13
`define CKR_AUX_DIV_MSB 12
`define CKR_AUX_DIV_LSB 11
`define CKR_AUX_SRC_BIT 9
`define CKR_CD_EN_BIT 8
`define CKR_CD_SRC_BIT 7
`define CKR_CD_FMT_MSB 4
`define CKR_CD_FMT_LSB 2
`define CKR_AB_EN_BIT 1
`define CKR_OE_POL_BIT 0
// writable masks: reserved bits hold their fixed values
`define CKR_WMASK_DIV1_AB 16'hffe7
`define CKR_WMASK_OE_AUX 16'h7b9f
`define CKR_FIXED_OE_AUX 16'h0400
// half periods in source edges for each divide code
`define CKR_HALF_CH1_1 5'h01
`define CKR_HALF_CH1_2 5'h02
`define CKR_HALF_CH1_3 5'h03
`define CKR_HALF_CH1_4 5'h04
`define CKR_HALF_CH1_5 5'h05
`define CKR_HALF_CH1_6 5'h0a
`define CKR_HALF_CH1_7 5'h14
`define CKR_HALF_AUX_1 5'h01
`define CKR_HALF_AUX_2 5'h02
`define CKR_HALF_AUX_3 5'h04
`endif

// file: hdl/ckr_pkg.sv
// types shared by the clock output routing block
`default_nettype none
package ckr_pkg;
  // one bit per driven pin
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
    logic aux;
  } ckr_pins_t;
  // decoded pair format
  typedef struct packed {
    logic first_on;
    logic second_on;
    logic invert;
  } ckr_fmt_t;
  // register access from the serial port's decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ckr_req_t;
  typedef enum logic [1:0] {
    CKR_AUX_LOW,
    CKR_AUX_HIZ,
    CKR_AUX_CLOCK,
    CKR_AUX_READY
  } ckr_aux_func_t;
endpackage : ckr_pkg
`default_nettype wire

// file: tb/ckr_chk_sva.sv
// assertion checker for the clock output routing block
`default_nettype none
module ckr_chk
  import ckr_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_rst, // async reset
  input wire ckr_req_t i_req, // register access
  input wire logic [15:0] o_rdata, // read data
  input wire logic i_fuse_load, // fuse copy pulse
  input wire logic [15:0] i_fuse_oe_aux, // fuse image, second register
  input wire logic i_pair_ab_off_state, // a/b off state
  input wire logic i_pair_cd_off_state, // c/d off state
  input wire logic i_oe_pin, // enable pin
  input wire logic i_clk_ready, // ready status
  input wire ckr_pins_t o_pin_level, // pin levels
  input wire ckr_pins_t o_pin_drive, // pin enables
  input wire logic [7:0] o_frac_div1_numerator // numerator high byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sh, next_sh; // copy of the second register
  logic [2:0] up, next_up; // edges since reset, saturating
  // fuse load wins over a write in the same cycle
  always_comb begin
    next_sh = sh;
    next_up = (up == 3'h7) ? up : up + 3'h1;
    if (i_fuse_load) next_sh = i_fuse_oe_aux;
    else if (i_req.wr && i_req.addr == 8'h07) next_sh = i_req.wdata;
  end
  // synced inputs are stale for a few edges after reset, hence up
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sh <= 16'h5d1f;
      up <= 3'h0;
    end else begin
      sh <= next_sh;
      up <= next_up;
    end
  end
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  a_numer_write: assert property (
    i_req.wr && !i_fuse_load && i_req.addr == 8'h06 |=>
    o_frac_div1_numerator == $past(i_req.wdata[12:5]))
    else $error("numerator byte not taken from write");
  a_rd_fixed: assert property (
    i_req.rd && i_req.addr == 8'h07 |=>
    !o_rdata[15] && o_rdata[10] && o_rdata[6:5] == 2'h0)
    else $error("fixed bits of second register wrong");
  a_aux_low: assert property (
    $past(sh[14:13]) == 2'h0 |-> o_pin_drive.aux && !o_pin_level.aux)
    else $error("aux pin not held low");
  a_aux_float: assert property (
    $past(sh[14:13]) == 2'h1 |-> !o_pin_drive.aux)
    else $error("aux pin not released");
  a_aux_ready: assert property (
    up == 3'h7 && $past(sh[14:13]) == 2'h3 |->
    o_pin_drive.aux && o_pin_level.aux == $past(i_clk_ready, 3))
    else $error("aux pin does not follow ready status");
  a_cd_off: assert property (
    !$past(sh[8]) |-> o_pin_level[2:1] == 2'h0 &&
    o_pin_drive[2:1] == {2{!$past(i_pair_cd_off_state)}})
    else $error("c/d pair not off");
  a_ab_off: assert property (
    !$past(sh[1]) |-> o_pin_level[4:3] == 2'h0 &&
    o_pin_drive[4:3] == {2{!$past(i_pair_ab_off_state)}})
    else $error("a/b pair not off");
  a_oe_gate: assert property (
    up == 3'h7 && $past(sh[0]) == $past(i_oe_pin, 3) |->
    o_pin_level[4:1] == 4'h0)
    else $error("pins toggle while enable pin is off");
endmodule : ckr_chk
bind ckr_top ckr_chk u_chk (.i_clk, .i_rst, .i_req, .o_rdata,
  .i_fuse_load, .i_fuse_oe_aux, .i_pair_ab_off_state,
  .i_pair_cd_off_state, .i_oe_pin, .i_clk_ready, .o_pin_level,
  .o_pin_drive, .o_frac_div1_numerator);
`default_nettype wire

// file: tb/ckr_host.sv
// host model for the register port
`default_nettype none
module ckr_host
  import ckr_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic [15:0] i_rdata, // read data from the block
  output var ckr_req_t o_req // register access
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_req = '0;
  // one access, held over one capture edge; reserved bits kept fixed
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [15:0] d, output logic [15:0] q);
    @(posedge i_clk);
    #2;
    o_req.wr = w;
    o_req.rd = !w;
    o_req.addr = a;
    if (a == 8'h06) o_req.wdata = d & 16'hffe7;
    else o_req.wdata = (d & 16'h7b9f) | 16'h0400;
    @(posedge i_clk);
    #2;
    q = i_rdata;
    o_req = '0;
  endtask : xfer
endmodule : ckr_host
`default_nettype wire

// file: tb/tb_top.sv
// testbench for the clock output routing block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ckr_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, fl = 1'b0, fd0 = 1'b0, fd1 = 1'b0;
  logic ch0 = 1'b0, src = 1'b0, offab = 1'b0, offcd = 1'b0, oe = 1'b0;
  logic rdy = 1'b0;
  logic [15:0] rdat;
  logic [7:0] num;
  ckr_req_t req;
  ckr_pins_t lv, dr;
  int n_mismatch = 0, tests_run = 0, k = 0;
  int dv[8] = '{0, 2, 4, 6, 8, 10, 20, 40};
  int ad[4] = '{0, 2, 4, 8};
  always #12.5 i_clk = ~i_clk;
  // sources: fd0 period 8 cycles, fd1 10, ch0 12
  always @(posedge i_clk) begin
    #2;
    k = k + 1;
    if (k % 4 == 0) fd0 = ~fd0;
    if (k % 5 == 0) fd1 = ~fd1;
    if (k % 6 == 0) ch0 = ~ch0;
  end
  ckr_top uut (.i_clk, .i_rst, .i_req(req), .o_rdata(rdat),
    .i_fuse_load(fl), .i_fuse_div1_ab(16'h1547),
    .i_fuse_oe_aux(16'h5d1b), .i_fd0_clk(fd0), .i_fd1_clk(fd1),
    .i_ch0_clk(ch0), .i_ch1_src(src), .i_pair_ab_off_state(offab),
    .i_pair_cd_off_state(offcd), .i_oe_pin(oe), .i_clk_ready(rdy),
    .o_pin_level(lv), .o_pin_drive(dr), .o_frac_div1_numerator(num));
  ckr_host host (.i_clk, .i_rdata(rdat), .o_req(req));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] x;
    host.xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] x;
    host.xfer(1'b0, a, 16'h0, x);
    chk(x, e);
  endtask : rd
  // cycles between 2nd and 3rd rise of a pin; the first may be a glitch
  task automatic per(input int b, output int p);
    logic o;
    int n, r, t;
    p = 0;
    r = 0;
    t = 0;
    o = lv[b];
    for (n = 0; n < 1100 && r < 3; n++) begin
      @(posedge i_clk);
      #2;
      if (lv[b] && !o) begin
        r++;
        if (r == 3) p = n - t;
        t = n;
      end
      o = lv[b];
    end
  endtask : per
  task automatic t_regs();
    rd(8'h06, 16'h0aa7);
    rd(8'h07, 16'h5d1f);
    chk({8'h0, num}, 16'h0055);
    rd(8'h09, 16'h0000);
    wr(8'h06, 16'h2a84);
    chk({8'h0, num}, 16'h0054);
    @(posedge i_clk);
    #2 fl = 1'b1;
    @(posedge i_clk);
    #2 fl = 1'b0;
    rd(8'h06, 16'h1547);
    rd(8'h07, 16'h5d1b);
    chk({8'h0, num}, 16'h00aa);
    $display("done regs");
  endtask : t_regs
  task automatic t_div();
    int p;
    wr(8'h07, 16'h5d9f);
    for (int c = 0; c < 8; c++) begin
      wr(8'h06, {c[2:0], 13'h0007});
      per(2, p);
      chk(p[15:0], 16'(8 * dv[c]));
    end
    src = 1'b1;
    wr(8'h06, 16'h2007);
    per(2, p);
    chk(p[15:0], 16'd20);
    src = 1'b0;
    wr(8'h07, 16'h5d1f);
    per(2, p);
    chk(p[15:0], 16'd12);
    $display("done divider");
  endtask : t_div
  task automatic t_fmt();
    int p;
    logic [15:0] e;
    for (int f = 4; f < 8; f++) begin
      wr(8'h06, {13'h0, f[2:0]});
      wr(8'h07, 16'h5d03 | {11'h0, f[2:0], 2'h0});
      for (int b = 1; b < 5; b++) begin
        per(b, p);
        e = (f == ((b % 2) ? 4 : 5)) ? 16'd0 : 16'd12;
        chk(p[15:0], e);
      end
      // second pin of each pair inverted only for format 6
      if (f > 5) begin
        e = {14'h0, lv.a ^ (f == 6), lv.c ^ (f == 6)};
        chk({14'h0, lv.b, lv.d}, e);
      end
    end
    $display("done format");
  endtask : t_fmt
  task automatic t_off();
    offcd = 1'b1;
    wr(8'h07, 16'h5c1d);
    repeat (4) @(posedge i_clk);
    #2;
    chk({8'h0, dr[4:1], lv[4:1]}, 16'h00c0);
    offab = 1'b1;
    offcd = 1'b0;
    repeat (4) @(posedge i_clk);
    #2;
    chk({8'h0, dr[4:1], lv[4:1]}, 16'h0030);
    $display("done off");
  endtask : t_off
  task automatic t_oe();
    int p;
    wr(8'h07, 16'h5d1e);
    per(4, p);
    chk(p[15:0], 16'd0);
    oe = 1'b1;
    per(4, p);
    chk(p[15:0], 16'd12);
    oe = 1'b0;
    wr(8'h07, 16'h5d1f);
    per(4, p);
    chk(p[15:0], 16'd12);
    $display("done enable pin");
  endtask : t_oe
  task automatic t_aux();
    int p;
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        wr(8'h07, {1'b0, 2'h2, c[1:0], 1'b1, s[0], 9'h11f});
        per(0, p);
        chk(p[15:0], 16'(ad[c] * (s ? 10 : 8)));
      end
    end
    wr(8'h07, 16'h1d1f);
    repeat (2) @(posedge i_clk);
    #2;
    chk({14'h0, dr.aux, lv.aux}, 16'h0002);
    wr(8'h07, 16'h3d1f);
    repeat (2) @(posedge i_clk);
    #2;
    chk({15'h0, dr.aux}, 16'h0000);
    wr(8'h07, 16'h7d1f);
    rdy = 1'b1;
    repeat (5) @(posedge i_clk);
    #2;
    chk({14'h0, dr.aux, lv.aux}, 16'h0003);
    $display("done aux");
  endtask : t_aux
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // watchdog, well past the expected run of about 12k cycles
  initial begin
    #(25 * 80000);
    n_mismatch++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    test_done();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    #2 i_rst = 1'b0;
    t_regs();
    t_div();
    t_fmt();
    t_off();
    t_oe();
    t_aux();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
